// ---- hdl/bal_unit.sv ----
// bal_unit.sv: eight-bit execution unit with register file and status flags
// assumes: one request per cycle while READY is high; single clock domain
//
// What this block does
// - Add two registers, optional carry in; flags Z C N V H; one clock.
// - Add constant to register pair by low register; Z C N V S; two clocks.
// - Subtract register, optional carry; flags Z C N V H; one clock.
// - Subtract constant from destination; flags Z C N V H; one clock.
// - Subtract constant and carry from destination; Z C N V H; one clock.
// - Subtract constant from register pair; Z C N V S; two clocks.
// - AND with register or constant; only Z N V S updated; one clock.
// - OR with register or constant, XOR registers; Z N V; one clock.
`timescale 1ns/1ps
`include "bal_cfg.svh"
module bal_unit (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input wire bal_pkg::bal_req_s REQ,
  output logic READY,
  output logic DONE,
  output logic [7:0] RESULT,
  output logic [7:0] SREG,
  input wire logic [4:0] PEEK_ADDR,
  output logic [7:0] PEEK_DATA
);
  logic [7:0] regs_reg [0:31];
  logic [7:0] sreg_reg;
  logic [7:0] result_reg;
  logic done_reg;
  bal_pkg::bal_state_e state_reg;
  logic [4:0] hi_idx_reg;
  logic [7:0] hi_val_reg;
  logic carry_reg;
  logic word_sub_reg;
  logic lo_zero_reg;

  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] res_next;
  logic [7:0] sreg_next;
  logic cin;
  logic sub;
  logic logic_op;
  logic write_en;
  logic [8:0] wide;
  logic [4:0] half;
  logic take;

  assign take = REQ_VALID && READY;
  assign READY = (state_reg == bal_pkg::BAL_IDLE);
  assign DONE = done_reg;
  assign RESULT = result_reg;
  assign SREG = sreg_reg;
  assign PEEK_DATA = regs_reg[PEEK_ADDR];

  ////////////////////////////////////////////////////////////////////////////
  // operand select and byte arithmetic
  always_comb begin
    a = regs_reg[REQ.dst];
    b = regs_reg[REQ.src];
    cin = 1'b0;
    sub = 1'b0;
    logic_op = 1'b0;
    write_en = 1'b1;
    res_next = 8'h00;
    wide = 9'h000;
    half = 5'h00;
    sreg_next = sreg_reg;
    case (REQ.op)
      `BAL_OP_ADC: cin = sreg_reg[`BAL_SF_C];
      `BAL_OP_SUB: sub = 1'b1;
      `BAL_OP_SUBB: begin
        sub = 1'b1;
        cin = sreg_reg[`BAL_SF_C];
      end
      `BAL_OP_SUBK: begin
        sub = 1'b1;
        b = REQ.imm;
      end
      `BAL_OP_SBCK: begin
        sub = 1'b1;
        b = REQ.imm;
        cin = sreg_reg[`BAL_SF_C];
      end
      `BAL_OP_ANDK, `BAL_OP_ORK: begin
        b = REQ.imm;
        logic_op = 1'b1;
      end
      `BAL_OP_AND, `BAL_OP_OR, `BAL_OP_XOR: logic_op = 1'b1;
      `BAL_OP_WADD: b = {2'b00, REQ.imm[5:0]};
      `BAL_OP_WSUB: begin
        sub = 1'b1;
        b = {2'b00, REQ.imm[5:0]};
      end
      `BAL_OP_ADD: cin = 1'b0;
      default: write_en = 1'b0;
    endcase
    if (logic_op) begin
      case (REQ.op)
        `BAL_OP_AND, `BAL_OP_ANDK: res_next = a & b;
        `BAL_OP_OR, `BAL_OP_ORK: res_next = a | b;
        default: res_next = a ^ b;
      endcase
      sreg_next[`BAL_SF_Z] = (res_next == 8'h00);
      sreg_next[`BAL_SF_N] = res_next[7];
      sreg_next[`BAL_SF_V] = 1'b0;
      sreg_next[`BAL_SF_S] = res_next[7];
    end else if (sub) begin
      wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      res_next = wide[7:0];
      sreg_next[`BAL_SF_C] = wide[8];
      sreg_next[`BAL_SF_H] = half[4];
      sreg_next[`BAL_SF_V] = (a[7] ^ b[7]) & (a[7] ^ res_next[7]);
    end else begin
      wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      res_next = wide[7:0];
      sreg_next[`BAL_SF_C] = wide[8];
      sreg_next[`BAL_SF_H] = half[4];
      sreg_next[`BAL_SF_V] = ~(a[7] ^ b[7]) & (a[7] ^ res_next[7]);
    end
    if (!logic_op) begin
      sreg_next[`BAL_SF_N] = res_next[7];
      sreg_next[`BAL_SF_S] = res_next[7] ^ sreg_next[`BAL_SF_V];
      // borrow chains keep zero only if it was already set
      if (cin && sub && REQ.op != `BAL_OP_WSUB)
        sreg_next[`BAL_SF_Z] = (res_next == 8'h00) & sreg_reg[`BAL_SF_Z];
      else
        sreg_next[`BAL_SF_Z] = (res_next == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high byte of word ops, second clock
  logic [8:0] hi_wide;
  logic [7:0] hi_res;
  logic hi_v;
  always_comb begin
    if (word_sub_reg)
      hi_wide = {1'b0, hi_val_reg} - {8'h00, carry_reg};
    else
      hi_wide = {1'b0, hi_val_reg} + {8'h00, carry_reg};
    hi_res = hi_wide[7:0];
    if (word_sub_reg)
      hi_v = hi_val_reg[7] & ~hi_res[7];
    else
      hi_v = ~hi_val_reg[7] & hi_res[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer for the two-clock word ops
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= bal_pkg::BAL_IDLE;
      hi_idx_reg <= 5'h00;
      hi_val_reg <= 8'h00;
      carry_reg <= 1'b0;
      word_sub_reg <= 1'b0;
      lo_zero_reg <= 1'b0;
    end else begin
      case (state_reg)
        bal_pkg::BAL_IDLE: begin
          if (take && (REQ.op == `BAL_OP_WADD ||
              REQ.op == `BAL_OP_WSUB)) begin
            state_reg <= bal_pkg::BAL_HIGH;
            hi_idx_reg <= REQ.dst + 5'h01;
            hi_val_reg <= regs_reg[REQ.dst + 5'h01];
            carry_reg <= wide[8];
            word_sub_reg <= (REQ.op == `BAL_OP_WSUB);
            lo_zero_reg <= (res_next == 8'h00);
          end
        end
        bal_pkg::BAL_HIGH: state_reg <= bal_pkg::BAL_IDLE;
        default: state_reg <= bal_pkg::BAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file writes
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 32; i++)
        regs_reg[i] <= 8'h00;
    end else if (state_reg == bal_pkg::BAL_HIGH) begin
      regs_reg[hi_idx_reg] <= hi_res;
    end else if (take && write_en) begin
      regs_reg[REQ.dst] <= res_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register, result and completion
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sreg_reg <= `BAL_SREG_RST;
      result_reg <= 8'h00;
      done_reg <= 1'b0;
    end else if (state_reg == bal_pkg::BAL_HIGH) begin
      sreg_reg[`BAL_SF_C] <= hi_wide[8];
      sreg_reg[`BAL_SF_Z] <= lo_zero_reg & (hi_res == 8'h00);
      sreg_reg[`BAL_SF_N] <= hi_res[7];
      sreg_reg[`BAL_SF_V] <= hi_v;
      sreg_reg[`BAL_SF_S] <= hi_res[7] ^ hi_v;
      result_reg <= hi_res;
      done_reg <= 1'b1;
    end else if (take && write_en) begin
      if (REQ.op == `BAL_OP_WADD || REQ.op == `BAL_OP_WSUB) begin
        done_reg <= 1'b0;
      end else begin
        // result stands until the next completion
        result_reg <= res_next;
        sreg_reg <= sreg_next;
        done_reg <= 1'b1;
      end
    end else begin
      done_reg <= 1'b0;
    end
  end
endmodule

// ---- hdl/bal_cfg.svh ----
// bal_cfg.svh: opcode codes, status bit positions and timing counts
// assumes: included by the package and the unit, no other dependency
`ifndef BAL_CFG_SVH
`define BAL_CFG_SVH
`define BAL_OP_ADD 4'h0
`define BAL_OP_ADC 4'h1
`define BAL_OP_SUB 4'h2
`define BAL_OP_SUBB 4'h3
`define BAL_OP_SUBK 4'h4
`define BAL_OP_SBCK 4'h5
`define BAL_OP_AND 4'h6
`define BAL_OP_ANDK 4'h7
`define BAL_OP_OR 4'h8
`define BAL_OP_ORK 4'h9
`define BAL_OP_XOR 4'hA
`define BAL_OP_WADD 4'hB
`define BAL_OP_WSUB 4'hC
`define BAL_SF_C 0
`define BAL_SF_Z 1
`define BAL_SF_N 2
`define BAL_SF_V 3
`define BAL_SF_S 4
`define BAL_SF_H 5
`define BAL_SREG_RST 8'h00
`define BAL_BYTE_CLOCKS 1
`define BAL_WORD_CLOCKS 2
`endif

// ---- hdl/bal_pkg.sv ----
// bal_pkg.sv: types shared by the byte arithmetic logic unit
// assumes: bal_cfg.svh is on the include path
`include "bal_cfg.svh"
package bal_pkg;
  typedef logic [3:0] bal_op_t;
  typedef struct packed {
    logic [3:0] op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
  } bal_req_s;
  typedef enum logic [1:0] {
    BAL_IDLE = 2'b00,
    BAL_HIGH = 2'b01
  } bal_state_e;
endpackage

// ---- tb/bal_rf_model.sv ----
// expected register file contents for the bench
// assumes: the bench writes it as each request is issued
`timescale 1ns/1ps
module bal_rf_model;
  logic [7:0] rf [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      rf[i] = 8'h00;
    end
  end
endmodule

// ---- tb/bal_unit_chk.sv ----
// port assertions for the execution unit
// assumes: one clock domain, bound into bal_unit
`timescale 1ns/1ps
module bal_unit_chk (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input wire bal_pkg::bal_req_s REQ,
  input wire logic READY,
  input wire logic DONE,
  input wire logic [7:0] RESULT,
  input wire logic [7:0] SREG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  logic tk;
  logic [3:0] op;
  assign tk = REQ_VALID && READY;
  assign op = REQ.op;
  chk_byte_done:
    assert property (tk && op <= 4'hA |=> DONE) else $error("byte late");
  chk_word_add:
    assert property (tk && op == 4'hB |=> !READY && !DONE ##1 DONE && READY)
    else $error("add word timing");
  chk_word_sub:
    assert property (tk && op == 4'hC |=> !READY && !DONE ##1 DONE && READY)
    else $error("sub word timing");
  chk_sub_const:
    assert property (tk && op inside {4'h4, 4'h5} |=> DONE &&
      SREG[2] == RESULT[7] && SREG[4] == (SREG[2] ^ SREG[3]))
    else $error("const sub flags");
  chk_arith_sign:
    assert property (tk && op <= 4'h3 |=> SREG[2] == RESULT[7] &&
      SREG[4] == (SREG[2] ^ SREG[3])) else $error("arith sign");
  chk_logic_keep:
    assert property (tk && op inside {[4'h6:4'hA]} |=> !SREG[3] &&
      SREG[0] == $past(SREG[0]) && SREG[5] == $past(SREG[5]))
    else $error("logic kept flags");
  chk_logic_flags:
    assert property (tk && op inside {[4'h6:4'hA]} |=> SREG[1] ==
      (RESULT == 8'h00) && SREG[2] == RESULT[7]) else $error("logic flags");
  chk_quiet_hold:
    assert property (!DONE |-> $stable(SREG) && $stable(RESULT))
    else $error("output moved");
endmodule
bind bal_unit bal_unit_chk u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .READY(READY), .DONE(DONE),
  .RESULT(RESULT), .SREG(SREG));

// ---- tb/byte_arith_logic_unit_tb_top.sv ----
// self-checking bench for the execution unit
// assumes: package, unit, checker and model compiled first
`timescale 1ns/1ps
module byte_arith_logic_unit_tb_top;
  logic CLK_SYS = 0, RESETN = 0, REQ_VALID = 0, READY, DONE;
  bal_pkg::bal_req_s REQ = '0;
  logic [7:0] RESULT, SREG, PEEK_DATA, fx = 0;
  logic [4:0] PEEK_ADDR = 0;
  int n_mismatch = 0, samples_checked = 0;
  always #50 CLK_SYS = ~CLK_SYS;
  bal_unit dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .READY(READY), .DONE(DONE), .RESULT(RESULT), .SREG(SREG),
    .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA));
  bal_rf_model m ();
  task automatic cmp8(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_op(input logic [3:0] o, input logic [4:0] d, s,
    input logic [7:0] k);
    logic [7:0] a, b, r, hi;
    logic [16:0] x;
    logic [4:0] h;
    logic c, v, sb;
    a = m.rf[d];
    hi = m.rf[d + 5'd1];
    b = (o inside {4'h4, 4'h5, 4'h7, 4'h9}) ? k : m.rf[s];
    sb = o inside {4'h2, 4'h3, 4'h4, 4'h5, 4'hC};
    c = fx[0] && (o inside {4'h1, 4'h3, 4'h5});
    if (o > 4'hA) begin
      x = sb ? {1'b0, hi, a} - k[5:0] : {1'b0, hi, a} + k[5:0];
      v = sb ? hi[7] & ~x[15] : ~hi[7] & x[15];
      r = x[15:8];
      fx = {2'b0, fx[5], x[15] ^ v, v, x[15], x[15:0] == 0, x[16]};
      m.rf[d + 5'd1] = r;
      m.rf[d] = x[7:0];
    end else if (o > 4'h5) begin
      r = o == 4'hA ? a ^ b : o > 4'h7 ? a | b : a & b;
      fx = {2'b0, fx[5], r[7], 1'b0, r[7], r == 0, fx[0]};
      m.rf[d] = r;
    end else begin
      x = sb ? a - b - c : a + b + c;
      h = sb ? a[3:0] - b[3:0] - c : a[3:0] + b[3:0] + c;
      r = x[7:0];
      v = sb ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])
             : (a[7] ~^ b[7]) & (r[7] ^ a[7]);
      fx = {2'b0, h[4], r[7] ^ v, v, r[7],
            r == 0 && (!(sb && c) || fx[1]), x[8]};
      m.rf[d] = r;
    end
    REQ = '{o, d, s, k};
    REQ_VALID = 1;
    PEEK_ADDR = d;
    @(posedge CLK_SYS) #1;
    if (o > 4'hA) begin
      cmp8("ready", 8'h00, {7'h0, READY});
      cmp8("low", m.rf[d], PEEK_DATA);
      REQ = '{4'h9, 5'd9, 5'd0, 8'h5A};
      PEEK_ADDR = d + 5'd1;
      @(posedge CLK_SYS) #1;
    end
    cmp8("done", 8'h01, {7'h0, DONE});
    cmp8("result", r, RESULT);
    cmp8("sreg", fx, SREG);
    cmp8("reg", m.rf[PEEK_ADDR], PEEK_DATA);
  endtask
  task automatic t_logic();
    do_op(4'h9, 5'd16, 5'd0, 8'h7F);
    do_op(4'h9, 5'd17, 5'd0, 8'h81);
    do_op(4'h6, 5'd16, 5'd17, 8'h00);
    do_op(4'h7, 5'd17, 5'd0, 8'h80);
    do_op(4'h8, 5'd16, 5'd17, 8'h00);
    do_op(4'hA, 5'd16, 5'd16, 8'h00);
    $display("t_logic done");
  endtask
  task automatic t_arith();
    do_op(4'h0, 5'd17, 5'd17, 8'h00);
    do_op(4'h5, 5'd21, 5'd0, 8'hFF);
    do_op(4'hA, 5'd19, 5'd19, 8'h00);
    do_op(4'h9, 5'd18, 5'd0, 8'h0F);
    do_op(4'h1, 5'd18, 5'd18, 8'h00);
    do_op(4'h9, 5'd20, 5'd0, 8'h7F);
    do_op(4'h9, 5'd19, 5'd0, 8'h01);
    do_op(4'h0, 5'd20, 5'd19, 8'h00);
    do_op(4'h2, 5'd18, 5'd20, 8'h00);
    do_op(4'h3, 5'd18, 5'd18, 8'h00);
    do_op(4'h4, 5'd18, 5'd0, 8'hFF);
    do_op(4'h5, 5'd18, 5'd0, 8'h01);
    do_op(4'h5, 5'd18, 5'd0, 8'hFE);
    $display("t_arith done");
  endtask
  task automatic t_word();
    do_op(4'h9, 5'd24, 5'd0, 8'hFF);
    do_op(4'h9, 5'd25, 5'd0, 8'h7F);
    do_op(4'hB, 5'd24, 5'd0, 8'hC1);
    do_op(4'hC, 5'd24, 5'd0, 8'h01);
    do_op(4'hC, 5'd26, 5'd0, 8'h3F);
    do_op(4'hB, 5'd26, 5'd0, 8'h3F);
    REQ_VALID = 0;
    PEEK_ADDR = 5'd9;
    @(posedge CLK_SYS) #1;
    cmp8("refused", m.rf[9], PEEK_DATA);
    cmp8("idle", 8'h00, {7'h0, DONE});
    $display("t_word done");
  endtask
  initial begin
    repeat (6) @(posedge CLK_SYS);
    #1 RESETN = 1;
    t_logic();
    t_arith();
    t_word();
    give_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
